/* File: logic/gate_arm_pkg.sv */
/*
 * Shared constants and types for the gate-drive arming logic.
 * Assumes a single 100 MHz clock domain; no software-visible registers.
 */
`default_nettype none

package gate_arm_pkg;

    localparam int unsigned PHASES = 3;
    localparam int unsigned CLK_PERIOD_NS = 10;
    // Least time from both enables high until the device has left standby.
    localparam int unsigned STANDBY_EXIT_NS = 280;
    localparam int unsigned STANDBY_EXIT_CYCLES =
        (STANDBY_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] STANDBY_EXIT_CNT = 6'(STANDBY_EXIT_CYCLES);
    localparam logic [2:0] CMD_RESET = 3'h0;
    localparam logic [2:0] CMD_N_RESET = 3'h7;

    // Per-phase high-side arming progress.
    typedef enum logic [1:0] {
        hs_locked,
        hs_armed,
        hs_pulsed,
        hs_live
    } hs_state_t;

endpackage

`default_nettype wire

/* File: logic/gate_drive_init_arming.sv */
/*
 * Arming and lockout logic for six gate-drive channels of a three-phase
 * predriver. Assumes a host drives enables and phase inputs; the supply
 * and power-on-reset monitors are delivered as synchronous levels.
 */
// How it works
// - Gates low while supplies or reset bad
// - Gates high impedance after reset until command
// - Ignore phase inputs until both enables
// - High side locked until low side toggled
// - Armed high side needs on-then-off pulse
// - High edge before low toggle keeps lockout
// - Uninitialised high side treated as off
// - Completed pulse leaves high side driven off
// - Initialised outputs follow inputs until standby or fault
// - Fault drives low; standby drives all low sides low once any started, floats high; both relock
`timescale 1ns/1ps
`default_nettype none

module gate_drive_init_arming
    import gate_arm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic enable_first,
    input wire logic enable_second,
    input wire logic low_side_cmd_phase_a,
    input wire logic low_side_cmd_phase_b,
    input wire logic low_side_cmd_phase_c,
    input wire logic high_side_cmd_n_phase_a,
    input wire logic high_side_cmd_n_phase_b,
    input wire logic high_side_cmd_n_phase_c,
    input wire logic gate_drive_supply_ok,
    input wire logic logic_supply_ok,
    input wire logic power_on_reset,
    input wire logic shutdown_fault,
    output logic [2:0] low_gate_on,
    output logic [2:0] low_gate_oe_n,
    output logic [2:0] high_gate_on,
    output logic [2:0] high_gate_oe_n,
    output logic [2:0] high_side_ready,
    output logic standby_state
);
    import gate_arm_pkg::*;

    phase_edge_if edges();
    hs_state_t hs_state [PHASES];
    logic hold_off;
    logic both_enabled;
    logic enabled_prev;
    logic [5:0] wake_count;
    logic awake;
    logic low_started;
    logic [2:0] low_live;

    phase_edge_detect u_edges (
        .clk(clk),
        .rst(rst),
        .low_raw({low_side_cmd_phase_c, low_side_cmd_phase_b, low_side_cmd_phase_a}),
        .high_n_raw({high_side_cmd_n_phase_c, high_side_cmd_n_phase_b,
                     high_side_cmd_n_phase_a}),
        .edges(edges.source)
    );

    assign hold_off = ~gate_drive_supply_ok | ~logic_supply_ok | power_on_reset;
    assign both_enabled = enable_first & enable_second;

    // ************************************************************
    // Standby exit timer
    // ************************************************************
    // Enables are taken as synchronous, so the counter reads them directly.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wake_count <= 6'h00;
            enabled_prev <= 1'b0;
        end
        else
        begin
            enabled_prev <= both_enabled;
            if (!both_enabled || hold_off || shutdown_fault)
            begin
                wake_count <= 6'h00;
            end
            else if (wake_count != STANDBY_EXIT_CNT)
            begin
                wake_count <= wake_count + 6'h01;
            end
        end
    end

    assign awake = both_enabled && !hold_off && !shutdown_fault
                   && (wake_count == STANDBY_EXIT_CNT);

    // ************************************************************
    // Per-phase arming
    // ************************************************************
    genvar p;
    generate
        for (p = 0; p < PHASES; p++)
        begin : g_phase
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    hs_state[p] <= hs_locked;
                end
                else if (!awake)
                begin
                    hs_state[p] <= hs_locked;
                end
                else
                begin
                    case (hs_state[p])
                        hs_locked:
                        begin
                            if (edges.low_rise[p])
                            begin
                                hs_state[p] <= hs_armed;
                            end
                        end
                        hs_armed:
                        begin
                            if (edges.high_on_rise[p])
                            begin
                                hs_state[p] <= hs_pulsed;
                            end
                        end
                        hs_pulsed:
                        begin
                            if (edges.high_on_fall[p])
                            begin
                                hs_state[p] <= hs_live;
                            end
                        end
                        hs_live:
                        begin
                            hs_state[p] <= hs_live;
                        end
                        default:
                        begin
                            hs_state[p] <= hs_locked;
                        end
                    endcase
                end
            end

            // Low-side output only follows once a fresh rising edge was seen awake,
            // so a level already high at enable cannot switch the gate.
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    low_live[p] <= 1'b0;
                end
                else if (!awake)
                begin
                    low_live[p] <= 1'b0;
                end
                else if (edges.low_rise[p])
                begin
                    low_live[p] <= 1'b1;
                end
            end

            // ************************************************************
            // Output stage
            // ************************************************************
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    low_gate_on[p] <= 1'b0;
                    high_gate_on[p] <= 1'b0;
                    low_gate_oe_n[p] <= 1'b0;
                    high_gate_oe_n[p] <= 1'b0;
                    high_side_ready[p] <= 1'b0;
                end
                else if (hold_off || shutdown_fault)
                begin
                    low_gate_on[p] <= 1'b0;
                    high_gate_on[p] <= 1'b0;
                    low_gate_oe_n[p] <= 1'b0;
                    high_gate_oe_n[p] <= 1'b0;
                    high_side_ready[p] <= 1'b0;
                end
                else
                begin
                    // low side free of high side
                    low_gate_on[p] <= awake && low_live[p] && edges.low_level[p];
                    low_gate_oe_n[p] <= !low_started;
                    high_gate_oe_n[p] <= (hs_state[p] != hs_live);
                    high_gate_on[p] <= (hs_state[p] == hs_live) && edges.high_on_level[p];
                    high_side_ready[p] <= (hs_state[p] == hs_live);
                end
            end
        end
    endgenerate

    // Low sides float from reset release until the first command after wake.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            low_started <= 1'b0;
        end
        else if (hold_off)
        begin
            low_started <= 1'b0;
        end
        else if (awake && (|edges.low_rise))
        begin
            low_started <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            standby_state <= 1'b1;
        end
        else
        begin
            standby_state <= !awake;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_locked_idle(int q);
        (hs_state[q] == hs_locked) && !(awake && edges.low_rise[q]);
    endsequence

    a_hold_off_low: assert property (@(posedge clk) disable iff (rst)
        hold_off |=> (low_gate_on == 3'h0 && high_gate_on == 3'h0
                      && low_gate_oe_n == 3'h0 && high_gate_oe_n == 3'h0))
        else $error("gates not held low during hold-off");

    a_enables_gate: assert property (@(posedge clk) disable iff (rst)
        !both_enabled |=> ##1 (low_gate_on == 3'h0))
        else $error("low gate on while disabled");

    a_wake_delay: assert property (@(posedge clk) disable iff (rst)
        $rose(both_enabled) && !hold_off && !shutdown_fault |-> !awake)
        else $error("left standby with no delay");

    a_lock_until_arm: assert property (@(posedge clk) disable iff (rst)
        s_locked_idle(0) |=> hs_state[0] == hs_locked)
        else $error("high side skipped arming");

    a_pulse_init: assert property (@(posedge clk) disable iff (rst)
        (hs_state[1] == hs_pulsed) && awake && edges.high_on_fall[1]
        |=> ##1 (high_side_ready[1] && !high_gate_oe_n[1]))
        else $error("high side not live after pulse");

    a_uninit_off: assert property (@(posedge clk) disable iff (rst)
        !high_side_ready[2] |-> !high_gate_on[2])
        else $error("uninitialised high side driven on");

    a_standby_relock: assert property (@(posedge clk) disable iff (rst)
        !awake |=> (hs_state[0] == hs_locked && hs_state[1] == hs_locked
                    && hs_state[2] == hs_locked))
        else $error("high side not relocked in standby");

    a_live_follows: assert property (@(posedge clk) disable iff (rst)
        (hs_state[0] == hs_live) && awake && $stable(hs_state[0]) && !hold_off
        |=> high_gate_on[0] == $past(edges.high_on_level[0]))
        else $error("live high side not following input");

endmodule

`default_nettype wire

/* File: logic/phase_edge_detect.sv */
/*
 * Synchronises the six phase inputs and turns them into edge pulses.
 * Assumes inputs may change at any time relative to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module phase_edge_detect
    import gate_arm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] low_raw,
    input wire logic [2:0] high_n_raw,
    phase_edge_if.source edges
);
    logic [2:0] low_meta;
    logic [2:0] low_sync;
    logic [2:0] low_prev;
    logic [2:0] high_meta;
    logic [2:0] high_sync;
    logic [2:0] high_prev;

    // ************************************************************
    // Synchronisers and edge compare
    // ************************************************************
    // sync then compare
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            low_meta <= CMD_RESET;
            low_sync <= CMD_RESET;
            low_prev <= CMD_RESET;
            high_meta <= CMD_N_RESET;
            high_sync <= CMD_N_RESET;
            high_prev <= CMD_N_RESET;
        end
        else
        begin
            low_meta <= low_raw;
            low_sync <= low_meta;
            low_prev <= low_sync;
            high_meta <= high_n_raw;
            high_sync <= high_meta;
            high_prev <= high_sync;
        end
    end

    // High-side commands are active low, so they are inverted once here.
    assign edges.low_level = low_sync;
    assign edges.low_rise = low_sync & ~low_prev;
    assign edges.low_fall = ~low_sync & low_prev;
    assign edges.high_on_level = ~high_sync;
    assign edges.high_on_rise = ~high_sync & high_prev;
    assign edges.high_on_fall = high_sync & ~high_prev;

    a_edge_one_cycle: assert property (@(posedge clk) disable iff (rst)
        (|edges.low_rise) |=> ((edges.low_rise & $past(edges.low_rise)) == 3'h0))
        else $error("low-side edge pulse lasted more than one cycle");

endmodule

`default_nettype wire

/* File: logic/phase_edge_if.sv */
/*
 * Carries synchronised phase commands and their edge pulses from the
 * edge detector to the arming logic. Assumes one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

interface phase_edge_if;
    logic [2:0] low_level;
    logic [2:0] low_rise;
    logic [2:0] low_fall;
    logic [2:0] high_on_level;
    logic [2:0] high_on_rise;
    logic [2:0] high_on_fall;

    modport source (
        output low_level,
        output low_rise,
        output low_fall,
        output high_on_level,
        output high_on_rise,
        output high_on_fall
    );
    modport sink (
        input low_level,
        input low_rise,
        input low_fall,
        input high_on_level,
        input high_on_rise,
        input high_on_fall
    );
endinterface

`default_nettype wire

/* File: test/gate_drive_init_arming_bench.sv */
/*
 * Self-checking bench for the gate-drive arming block. Expected output
 * snapshots are queued by the sequence and compared on the falling edge.
 * Assumes the host model drives all phase pins; the bench drives monitors.
 */
`timescale 1ns/1ps
`default_nettype none

module gate_drive_init_arming_bench;
    import gate_arm_pkg::*;

    localparam int unsigned DEAD = 5;
    // Supply settling is shortened; the real wait is 2 ms.
    localparam int unsigned SETTLE_CYCLES = 200;
    localparam logic [15:0] ALL = 16'hffff;
    localparam logic [15:0] GATES = 16'hfff0;
    localparam logic [15:0] RDY = 16'h000e;

    typedef struct {string name; logic [15:0] mask; logic [15:0] value;} note_t;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic enable_first, enable_second;
    logic [2:0] low_cmd, high_cmd_n;
    logic [2:0] supply = 3'h3;
    logic shutdown_fault = 1'b0;
    logic [2:0] low_gate_on, low_gate_oe_n, high_gate_on, high_gate_oe_n, high_side_ready;
    logic standby_state;
    logic [15:0] snap;
    note_t notes[$];
    int mismatches = 0;
    int check_count = 0;
    int cycle_count = 0;
    logic [2:0] lo, hi;
    logic en_pick;

    always #5 clk = ~clk;

    assign snap = {low_gate_on, low_gate_oe_n, high_gate_on, high_gate_oe_n,
                   high_side_ready, standby_state};

    host_mcu_model #(.DEAD_CYCLES(DEAD)) host_u (
        .clk(clk),
        .enable_first(enable_first),
        .enable_second(enable_second),
        .low_cmd(low_cmd),
        .high_cmd_n(high_cmd_n)
    );

    gate_drive_init_arming dut_u (
        .clk(clk),
        .rst(rst),
        .enable_first(enable_first),
        .enable_second(enable_second),
        .low_side_cmd_phase_a(low_cmd[0]),
        .low_side_cmd_phase_b(low_cmd[1]),
        .low_side_cmd_phase_c(low_cmd[2]),
        .high_side_cmd_n_phase_a(high_cmd_n[0]),
        .high_side_cmd_n_phase_b(high_cmd_n[1]),
        .high_side_cmd_n_phase_c(high_cmd_n[2]),
        .gate_drive_supply_ok(supply[0]),
        .logic_supply_ok(supply[1]),
        .power_on_reset(supply[2]),
        .shutdown_fault(shutdown_fault),
        .low_gate_on(low_gate_on),
        .low_gate_oe_n(low_gate_oe_n),
        .high_gate_on(high_gate_on),
        .high_gate_oe_n(high_gate_oe_n),
        .high_side_ready(high_side_ready),
        .standby_state(standby_state)
    );

    // ************************************************************
    // Checking
    // ************************************************************
    function automatic logic [15:0] outs(input logic [2:0] lon, input logic [2:0] loe,
        input logic [2:0] hon, input logic [2:0] hoe, input logic [2:0] rdy, input logic sb);
        return {lon, loe, hon, hoe, rdy, sb};
    endfunction

    task automatic check_value(input string name, input logic [15:0] seen,
        input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic expect_out(input string name, input logic [15:0] mask,
        input logic [15:0] value);
        notes.push_back('{name, mask, value});
    endtask

    // Notes are taken on the falling edge, when registered outputs are settled.
    always @(negedge clk)
    begin
        note_t n;
        while (notes.size() > 0)
        begin
            n = notes.pop_front();
            check_value(n.name, snap & n.mask, n.value & n.mask);
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycle_count++;
        if (cycle_count == 4000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    // ************************************************************
    // Sequence
    // ************************************************************
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (11) @(posedge clk);
        expect_out("in reset", ALL, outs(3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 1'b1));
        @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        expect_out("after reset", ALL, outs(3'h0, 3'h7, 3'h0, 3'h7, 3'h0, 1'b1));
        $display("test reset done");
    endtask

    initial
    begin
        void'($urandom(22));
        do_reset();
        host_u.wait_cycles(SETTLE_CYCLES);

        // One enable alone, picked at random, must leave the phase inputs without effect.
        en_pick = 1'($urandom);
        host_u.set_enables(en_pick, ~en_pick);
        host_u.drive(3'h7, 3'h0);
        host_u.wait_cycles(6);
        host_u.drive(3'h0, 3'h7);
        host_u.wait_cycles(6);
        expect_out("one enable", ALL, outs(3'h0, 3'h7, 3'h0, 3'h7, 3'h0, 1'b1));
        $display("test ignored before wake done");

        host_u.wake();
        host_u.drive(3'h0, 3'h5);
        host_u.wait_cycles(DEAD + 10);
        host_u.drive(3'h0, 3'h7);
        host_u.wait_cycles(8);
        expect_out("early high", ALL, outs(3'h0, 3'h7, 3'h0, 3'h7, 3'h0, 1'b0));
        $display("test early high edge done");

        host_u.drive(3'h7, 3'h7);
        host_u.wait_cycles(10);
        expect_out("low on armed", ALL, outs(3'h7, 3'h0, 3'h0, 3'h7, 3'h0, 1'b0));
        host_u.wait_cycles(90);
        host_u.drive(3'h0, 3'h0);
        host_u.wait_cycles(DEAD + 10);
        expect_out("high on only", RDY, 16'h0000);
        host_u.drive(3'h0, 3'h7);
        host_u.wait_cycles(8);
        expect_out("initialised", ALL, outs(3'h0, 3'h0, 3'h0, 3'h0, 3'h7, 1'b0));
        $display("test arming done");

        repeat (16)
        begin
            lo = 3'($urandom);
            hi = 3'($urandom) & ~lo;
            host_u.drive(lo, ~hi);
            host_u.wait_cycles(8);
            expect_out("follow", ALL, outs(lo, 3'h0, hi, 3'h0, 3'h7, 1'b0));
        end
        $display("test normal control done");

        host_u.drive(3'h0, 3'h0);
        host_u.wait_cycles(8);
        @(posedge clk);
        shutdown_fault <= 1'b1;
        host_u.wait_cycles(5);
        expect_out("fault", ALL, outs(3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 1'b1));
        @(posedge clk);
        shutdown_fault <= 1'b0;
        host_u.wait_cycles(STANDBY_EXIT_CYCLES + 6);
        host_u.drive(3'h0, 3'h7);
        host_u.drive(3'h0, 3'h0);
        host_u.wait_cycles(DEAD + 10);
        host_u.drive(3'h0, 3'h7);
        host_u.wait_cycles(8);
        expect_out("relocked", RDY | 16'h0380, 16'h0000);
        host_u.init_sequence(10);
        expect_out("recovered", GATES | RDY, outs(3'h0, 3'h0, 3'h0, 3'h0, 3'h7, 1'b0));
        $display("test fault recovery done");

        host_u.drive(3'h7, 3'h7);
        host_u.wait_cycles(8);
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk);
            // Bit k always goes bad; the other monitors go bad at random.
            supply <= 3'h3 ^ (3'($urandom) | (3'h1 << k));
            host_u.wait_cycles(5);
            expect_out("hold off", GATES, 16'h0000);
            @(posedge clk);
            supply <= 3'h3;
            host_u.wait_cycles(5);
        end
        $display("test hold off done");

        host_u.set_enables(1'b0, 1'b0);
        host_u.drive(3'h0, 3'h7);
        do_reset();
        // Let the checker take the last note before the verdict.
        host_u.wait_cycles(1);
        give_verdict();
    end
endmodule

`default_nettype wire

/* File: test/host_mcu_model.sv */
/*
 * Behavioural host controller that drives the enables and the six phase
 * commands of the gate-drive arming block. Assumes one clock and a caller
 * that sequences its tasks. Serial configuration is not modelled.
 */
`timescale 1ns/1ps
`default_nettype none

module host_mcu_model
    import gate_arm_pkg::*;
#(
    parameter int unsigned DEAD_CYCLES = 5
)
(
    input wire logic clk,
    output logic enable_first,
    output logic enable_second,
    output logic [2:0] low_cmd,
    output logic [2:0] high_cmd_n
);
    import gate_arm_pkg::*;

    // ************************************************************
    // Pin drivers
    // ************************************************************
    initial
    begin
        enable_first = 1'b0;
        enable_second = 1'b0;
        low_cmd = 3'h0;
        high_cmd_n = 3'h7;
    end

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic set_enables(input logic a, input logic b);
        @(posedge clk);
        enable_first <= a;
        enable_second <= b;
    endtask

    task automatic wake();
        set_enables(1'b1, 1'b1);
        wait_cycles(STANDBY_EXIT_CYCLES + 4);
    endtask

    task automatic drive(input logic [2:0] lo, input logic [2:0] hi_n);
        @(posedge clk);
        low_cmd <= lo;
        high_cmd_n <= hi_n;
    endtask

    // ************************************************************
    // Arming sequence
    // ************************************************************
    // low toggle first
    task automatic init_sequence(input int low_width);
        drive(3'h7, 3'h7);
        wait_cycles(low_width);
        drive(3'h0, 3'h7);
        drive(3'h0, 3'h0);
        wait_cycles(DEAD_CYCLES + 10);
        drive(3'h0, 3'h7);
        wait_cycles(8);
    endtask
endmodule

`default_nettype wire
